// >>> core/fifo_chain_pkg.sv
// Purpose: Constants shared by the chained fall-through FIFO design
// Assumes: Single clock mclk at 20 MHz
// Notes: Depths and widths are defaults of module parameters
package fifo_chain_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int STAGE_WIDTH = 18;
	localparam int STAGE_DEPTH = 16;
	localparam int STAGE_COUNT = 2;
	localparam int LANE_COUNT = 2;
	localparam int XFER_PERIODS = 4;
	localparam int READ_PERIODS = 3;
	localparam logic RESET_MODE = 1'b1;
endpackage

// >>> core/fifo_stage.sv
// Purpose: One fall-through FIFO stage and the expanded chain built from it
// Assumes: One clock; handshake flags active low like the device pins
// Notes: Word appears on the output without a read, fall-through style
`timescale 1ns/1ps

module fifo_stage #(
	parameter int WIDTH = fifo_chain_pkg::STAGE_WIDTH,
	parameter int DEPTH = fifo_chain_pkg::STAGE_DEPTH
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fallThroughMode,
	input wire logic [WIDTH-1:0] writeDataBus,
	input wire logic inValid,
	output logic inputSpace_n,
	output logic [WIDTH-1:0] readDataBus,
	output logic outputReady_n,
	input wire logic outReady,
	output logic emptyIndicator_n,
	output logic fullIndicator_n
);
	import fifo_chain_pkg::*;
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	logic [WIDTH-1:0] outWord_r;
	logic outFull_r;
	logic mode_r;

	// Ring pointer step, wraps at the stage depth
	function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] ptr);
		nextPtr = (ptr == AW'(DEPTH-1)) ? '0 : ptr + 1'b1;
	endfunction

	// Occupancy decode for the ring
	wire memEmpty = (count_r == '0);
	wire memFull = (count_r == (AW+1)'(DEPTH));
	wire push = inValid && !memFull;
	wire load = !memEmpty && (!outFull_r || outReady);
	wire pop = outFull_r && outReady;

	// Active-low flags as the pins show them
	assign inputSpace_n = memFull;
	assign outputReady_n = !outFull_r;
	assign readDataBus = outWord_r;
	assign emptyIndicator_n = !memEmpty || outFull_r;
	assign fullIndicator_n = !memFull;

	// Mode strap is captured during reset only
	// Changing the strap later has no effect until the next reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode_r <= fallThroughMode;
		end
	end

	// Storage write and pointers
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr_r] <= writeDataBus;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) wrPtr_r <= nextPtr(wrPtr_r);
			if (load) rdPtr_r <= nextPtr(rdPtr_r);
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(load);
		end
	end

	// Output register falls through without a read
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			outFull_r <= 1'b0;
			outWord_r <= '0;
		end else begin
			if (load) outWord_r <= mem[rdPtr_r];
			if (load) outFull_r <= 1'b1;
			else if (pop) outFull_r <= 1'b0;
		end
	end

	a_word_fall: assert property (@(posedge mclk) disable iff (!rst_n)
		(count_r == 1 && !outFull_r) |=> !outputReady_n) else $error("word did not fall through");
	a_full_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		(inValid && !inputSpace_n) |=> (count_r != 0 || !outputReady_n))
		else $error("accepted word lost");

	// Ring never holds more than its depth
	a_count_range: assert property (@(posedge mclk) disable iff (!rst_n)
		count_r <= (AW+1)'(DEPTH)) else $error("stage occupancy above depth");

	// Strap value stays put once reset has ended
	a_mode_kept: assert property (@(posedge mclk) disable iff (!rst_n)
		$stable(mode_r)) else $error("mode changed outside reset");
endmodule

// Width and depth expanded FIFO built from stages
module fifo_expansion #(
	parameter int WIDTH = fifo_chain_pkg::STAGE_WIDTH,
	parameter int DEPTH = fifo_chain_pkg::STAGE_DEPTH,
	parameter int STAGES = fifo_chain_pkg::STAGE_COUNT,
	parameter int LANES = fifo_chain_pkg::LANE_COUNT
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fallThroughMode,
	input wire logic [LANES*WIDTH-1:0] writeDataBus,
	input wire logic inValid,
	output logic inputSpace_n,
	output logic [LANES*WIDTH-1:0] readDataBus,
	output logic outputReady_n,
	input wire logic outReady,
	output logic emptyIndicator_n,
	output logic fullIndicator_n
);
	import fifo_chain_pkg::*;
	logic [WIDTH-1:0] data [LANES][STAGES+1];
	logic [LANES-1:0] space_n [STAGES];
	logic [LANES-1:0] ready_n [STAGES];
	logic [LANES-1:0] emptyL_n;
	logic [LANES-1:0] fullL_n;
	logic [STAGES:0] advWr;
	// Per lane, per stage occupancy flags, high while a stage holds a word
	wire [STAGES-1:0] laneEmpty_n [LANES];
	// Whole chain holds nothing in any lane
	wire chainIdle;
	// Worst ripple time of the first word, in mclk cycles
	localparam int RIPPLE_MAX = (STAGES - 1) * XFER_PERIODS + READ_PERIODS;

	assign chainIdle = (emptyL_n == '0);

	// Shared controls; OR of active-low ready flags per stage
	assign advWr[0] = inValid && !(|space_n[0]);
	assign inputSpace_n = |space_n[0];
	assign outputReady_n = |ready_n[STAGES-1];
	assign emptyIndicator_n = &emptyL_n;
	assign fullIndicator_n = &fullL_n;

	genvar l, s;
	generate
		for (s = 1; s <= STAGES; s++) begin : g_adv
			// Upstream output-ready writes next; downstream space reads upstream
			if (s == STAGES) begin : g_last
				assign advWr[s] = outReady && !(|ready_n[s-1]);
			end else begin : g_mid
				assign advWr[s] = !(|ready_n[s-1]) && !(|space_n[s]);
			end
		end
		for (l = 0; l < LANES; l++) begin : g_lane
			assign data[l][0] = writeDataBus[l*WIDTH +: WIDTH];
			assign readDataBus[l*WIDTH +: WIDTH] = data[l][STAGES];
			for (s = 0; s < STAGES; s++) begin : g_stage
				fifo_stage #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_stage (
					.mclk(mclk),
					.rst_n(rst_n),
					.fallThroughMode(fallThroughMode),
					.writeDataBus(data[l][s]),
					.inValid(advWr[s]),
					.inputSpace_n(space_n[s][l]),
					.readDataBus(data[l][s+1]),
					.outputReady_n(ready_n[s][l]),
					.outReady(advWr[s+1]),
					.emptyIndicator_n(laneEmpty_n[l][s]),
					.fullIndicator_n()
				);
			end
			// Lane holds data if any of its stages does
			assign emptyL_n[l] = |laneEmpty_n[l];
			// Lane is full once its first stage has no room
			assign fullL_n[l] = !space_n[0][l];
		end
	endgenerate

	// First word into an idle chain reaches the far end in bounded time
	a_ripple_bound: assert property (@(posedge mclk) disable iff (!rst_n)
		(advWr[0] && chainIdle) |-> ##[1:RIPPLE_MAX] !outputReady_n) else $error("ripple bound exceeded");

	// All lanes of the last stage agree on output-ready
	a_lane_match: assert property (@(posedge mclk) disable iff (!rst_n)
		(&ready_n[STAGES-1]) == (|ready_n[STAGES-1])) else $error("lane ready flags disagree");

	// Lanes of the first stage agree on input space
	a_space_match: assert property (@(posedge mclk) disable iff (!rst_n)
		(&space_n[0]) == (|space_n[0])) else $error("lane space flags disagree");

	// Held word stays on the bus while the reader stalls
	a_out_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		(!outputReady_n && !outReady) |=> (!outputReady_n && $stable(readDataBus)))
		else $error("output word changed while stalled");
endmodule

// >>> testbench/reader_model.sv
// Purpose: Downstream reader taking words from the chain
// Assumes: Reader changes outReady just after the edge
// Notes: stall holds the reader off; rnd makes it slow
`timescale 1ns/1ps
module reader_model (
	input wire logic mclk,
	input wire logic stall,
	input wire logic [15:0] rnd,
	output logic outReady
);
	// Take words on random cycles while not stalled
	initial outReady = 1'b0;
	always @(posedge mclk) begin
		outReady <= #1 !stall && rnd[0];
	end
endmodule

// >>> testbench/fifo_expansion_tb_top.sv
// Purpose: Self-checking bench of the expanded FIFO
// Assumes: Fall-through mode, default sizes
// Notes: Writes note expected words, a watcher compares reads
`timescale 1ns/1ps
module fifo_width_depth_expansion_tb_top;
	import fifo_chain_pkg::*;
	logic mclk = 0, rst_n = 0, inValid = 0, stall = 1;
	logic [35:0] wrWord = '0;
	logic [35:0] rdWord;
	logic inSpace_n, outReady_n, outReady, empty_n, full_n;
	logic [15:0] lfsr = 16'h0054;
	logic [15:0] rdRnd = 16'h0054;
	logic [35:0] expQ[$];
	int n_fail = 0, check_count = 0, sent = 0, lat;
	always #25 mclk = ~mclk;
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Reader pacing advances every cycle
	always @(posedge mclk) rdRnd <= lfsr_next(rdRnd);
	// Shared strap and controls for all lanes and stages
	fifo_expansion u_dut (.mclk(mclk), .rst_n(rst_n), .fallThroughMode(1'b1), .writeDataBus(wrWord),
		.inValid(inValid), .inputSpace_n(inSpace_n), .readDataBus(rdWord), .outputReady_n(outReady_n),
		.outReady(outReady), .emptyIndicator_n(empty_n), .fullIndicator_n(full_n));
	reader_model u_rd (.mclk(mclk), .stall(stall), .rnd(rdRnd), .outReady(outReady));
	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] want);
		check_count++;
		if (seen !== want) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Writer: random words, noted when accepted
	task automatic put(input int n);
		repeat (n) begin
			lfsr = lfsr_next(lfsr);
			wrWord = {lfsr[3:0], lfsr, ~lfsr};
			inValid = 1;
			if (inSpace_n === 1'b0) begin
				expQ.push_back(wrWord);
				sent++;
			end
			@(posedge mclk);
			#1;
		end
		inValid = 0;
	endtask
	// Let the reader empty the chain
	task automatic drain();
		stall = 0;
		for (int i = 0; i < 500 && expQ.size() > 0; i++) @(posedge mclk);
		repeat (3) @(posedge mclk);
		#1 check("emptyIndicator_n", empty_n, 36'h0);
		check("outputReady_n", outReady_n, 36'h1);
	endtask
	// Compare each word the reader takes
	always @(posedge mclk) begin
		if (rst_n && outReady && outReady_n === 1'b0)
			check("readDataBus", rdWord, expQ.size() ? expQ.pop_front() : 'x);
	end
	initial begin
		#2000000 n_fail++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge mclk);
		#1 rst_n = 1;
		put(1);
		for (lat = 1; lat < 20 && outReady_n !== 1'b0; lat++) begin
			@(posedge mclk);
			#1;
		end
		check("firstWordOk", lat <= (STAGE_COUNT - 1) * XFER_PERIODS + READ_PERIODS, 36'h1);
		drain();
		$display("test latency done");
		stall = 1;
		sent = 0;
		put(40);
		check("capacity", sent, STAGE_COUNT * (STAGE_DEPTH + 1));
		check("inputSpace_n", inSpace_n, 36'h1);
		check("fullIndicator_n", full_n, 36'h0);
		drain();
		check("inputSpace_n", inSpace_n, 36'h0);
		$display("test fill and drain done");
		stall = 0;
		put(60);
		drain();
		$display("test streaming done");
		report_and_stop();
	end
endmodule
